// ---- core/scsts_core.sv ----
// SCSI status registers behind an AHB-Lite slave, with event interrupt
`timescale 1ns/100ps
`include "scsts_consts.svh"

module scsts_core #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire scsts_pkg::scsts_htrans_t htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic in_latch_low_full,
  input wire logic in_latch_high_full,
  input wire logic out_buffer_low_full,
  input wire logic out_buffer_high_full,
  input wire logic out_latch_low_full,
  input wire logic out_latch_high_full,
  input wire logic in_latch_low_load,
  input wire logic in_latch_high_load,
  input wire logic [`SCSTS_FIFO_CNT_W-1:0] sync_fifo_count,
  input wire logic arb_started,
  input wire logic arb_sel_by_other,
  input wire logic arb_success,
  input wire logic arb_mode_full_sel,
  input wire logic interrupt_status_reset,
  input wire logic connected_flag,
  input wire logic block_move_exec,
  input wire logic scsi_rst_n,
  input wire logic scsi_sdp0_n,
  input wire logic scsi_sdp1_n,
  input wire logic scsi_req_n,
  input wire logic scsi_msg_n,
  input wire logic scsi_cd_n,
  input wire logic scsi_io_n
);
  import scsts_pkg::*;

  // Pin synchroniser; stage one feeds stage two only
  logic [`SCSTS_PIN_W-1:0] pin_meta_q;
  logic [`SCSTS_PIN_W-1:0] pin_sync_q;
  logic req_prev_q;
  logic [`SCSTS_PIN_W-1:0] pins_raw;
  logic [`SCSTS_PIN_W-1:0] pin_act;

  assign pins_raw = {scsi_io_n, scsi_cd_n, scsi_msg_n, scsi_req_n,
                     scsi_sdp1_n, scsi_sdp0_n, scsi_rst_n};
  // SCSI lines are active low; flip after synchronising
  assign pin_act = ~pin_sync_q;

  // Both stages reset to the released level, so no false REQ or RST edge follows reset
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta_q <= `SCSTS_RST_PINS;
    end else begin
      pin_meta_q <= pins_raw;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_sync_q <= `SCSTS_RST_PINS;
    end else begin
      pin_sync_q <= pin_meta_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      req_prev_q <= 1'b0;
    end else begin
      req_prev_q <= pin_act[`SCSTS_PIN_REQ];
    end
  end

  logic req_assert;
  assign req_assert = pin_act[`SCSTS_PIN_REQ] & ~req_prev_q;

  // Arbitration progress and outcome
  // Lost and won stay set until the next arbitration starts, so software can read them late
  logic aip_q;
  logic lost_q;
  logic won_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      aip_q <= 1'b0;
    end else if (arb_started) begin
      aip_q <= 1'b1;
    end else if (arb_sel_by_other || arb_success) begin
      aip_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lost_q <= 1'b0;
    end else if (aip_q && arb_sel_by_other) begin
      lost_q <= 1'b1;
    end else if (arb_started) begin
      lost_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      won_q <= 1'b0;
    end else if (aip_q && arb_success && arb_mode_full_sel) begin
      won_q <= 1'b1;
    end else if (arb_started) begin
      won_q <= 1'b0;
    end
  end

  // Latched parity, updated only when a new byte enters the input latch
  logic lpar_low_q;
  logic lpar_high_q;

  // Parity comes from the synchronised line, so a load pulse must trail the pin by two cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      lpar_low_q <= 1'b0;
    end else if (in_latch_low_load) begin
      lpar_low_q <= pin_act[`SCSTS_PIN_SDP0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lpar_high_q <= 1'b0;
    end else if (in_latch_high_load) begin
      lpar_high_q <= pin_act[`SCSTS_PIN_SDP1];
    end
  end

  // Phase lines captured on the asserting edge of REQ, either mode
  // Phase lines pass the same two stages as REQ, so they keep their setup to it
  logic [2:0] phase_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= 3'h0;
    end else if (req_assert) begin
      phase_q <= {pin_act[`SCSTS_PIN_MSG], pin_act[`SCSTS_PIN_CD],
                  pin_act[`SCSTS_PIN_IO]};
    end
  end

  // Last disconnect; set wins while not connected
  logic last_disconnect_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      last_disconnect_q <= `SCSTS_RST_LAST_DISCONNECT;
    end else if (!connected_flag) begin
      last_disconnect_q <= 1'b1;
    end else if (block_move_exec) begin
      last_disconnect_q <= 1'b0;
    end
  end

  // Register images
  // Unlatched fields are taken at the address edge and lag the pins by about three cycles
  scsts_byte_t stat0;
  scsts_byte_t stat1;
  scsts_byte_t stat2;

  always_comb begin
    stat0 = `SCSTS_RST_BYTE;
    stat0[`SCSTS_S0_IN_LOW] = in_latch_low_full;
    stat0[`SCSTS_S0_OUTBUF_LOW] = out_buffer_low_full;
    stat0[`SCSTS_S0_OUTLAT_LOW] = out_latch_low_full;
    stat0[`SCSTS_S0_AIP] = aip_q;
    stat0[`SCSTS_S0_LOST] = lost_q;
    stat0[`SCSTS_S0_WON] = won_q;
    stat0[`SCSTS_S0_RST] = pin_act[`SCSTS_PIN_RST] | interrupt_status_reset;
    stat0[`SCSTS_S0_PAR_LOW] = pin_act[`SCSTS_PIN_SDP0];
  end

  always_comb begin
    stat1 = `SCSTS_RST_BYTE;
    stat1[`SCSTS_S1_CNT_HI:`SCSTS_S1_CNT_LO] = sync_fifo_count[3:0];
    stat1[`SCSTS_S1_LPAR_LOW] = lpar_low_q;
    stat1[`SCSTS_S1_MSG] = phase_q[2];
    stat1[`SCSTS_S1_CD] = phase_q[1];
    stat1[`SCSTS_S1_IO] = phase_q[0];
  end

  always_comb begin
    stat2 = `SCSTS_RST_BYTE;
    stat2[`SCSTS_S2_IN_HIGH] = in_latch_high_full;
    stat2[`SCSTS_S2_OUTBUF_HIGH] = out_buffer_high_full;
    stat2[`SCSTS_S2_OUTLAT_HIGH] = out_latch_high_full;
    stat2[`SCSTS_S2_CNT_MSB] = sync_fifo_count[`SCSTS_FIFO_CNT_MSB];
    stat2[`SCSTS_S2_LPAR_HIGH] = lpar_high_q;
    stat2[`SCSTS_S2_LAST_DISCONNECT] = last_disconnect_q;
    stat2[`SCSTS_S2_PAR_HIGH] = pin_act[`SCSTS_PIN_SDP1];
  end

  // Event detection for the interrupt status
  logic lost_prev_q;
  logic won_prev_q;
  logic rst_prev_q;
  logic [`SCSTS_EV_W-1:0] events;

  // Edge detectors start at the idle level of what they watch
  always_ff @(posedge clk) begin
    if (rst) begin
      lost_prev_q <= 1'b0;
    end else begin
      lost_prev_q <= lost_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      won_prev_q <= 1'b0;
    end else begin
      won_prev_q <= won_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rst_prev_q <= 1'b0;
    end else begin
      rst_prev_q <= pin_act[`SCSTS_PIN_RST];
    end
  end

  always_comb begin
    events = `SCSTS_RST_EVENTS;
    events[`SCSTS_EV_LOST] = lost_q & ~lost_prev_q;
    events[`SCSTS_EV_WON] = won_q & ~won_prev_q;
    events[`SCSTS_EV_RST] = pin_act[`SCSTS_PIN_RST] & ~rst_prev_q;
    events[`SCSTS_EV_PHASE] = req_assert;
  end

  // AHB-Lite address phase decode
  logic acc;
  logic [`SCSTS_IDX_W-1:0] acc_idx;
  logic word_ok;

  // SEQ is taken like NONSEQ; only single word transfers are expected
  assign word_ok = (hsize == `SCSTS_HSIZE_WORD) && (haddr[1:0] == 2'b00);
  assign acc = hsel && hready && (htrans == SCSTS_NONSEQ || htrans == SCSTS_SEQ);
  assign acc_idx = haddr[`SCSTS_IDX_W+1:2];

  // Write data arrives a cycle after its address
  logic wr_pend_q;
  logic [`SCSTS_IDX_W-1:0] wr_idx_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= acc && hwrite && word_ok;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_idx_q <= '0;
    end else begin
      wr_idx_q <= acc_idx;
    end
  end

  logic wr_stat;
  logic wr_mask;
  assign wr_stat = wr_pend_q && (wr_idx_q == `SCSTS_IDX_INT_STAT);
  assign wr_mask = wr_pend_q && (wr_idx_q == `SCSTS_IDX_INT_MASK);

  logic [`SCSTS_EV_W-1:0] int_stat_q;
  logic [`SCSTS_EV_W-1:0] int_mask_q;

  // Write one to clear; a new event in the same cycle stays set
  always_ff @(posedge clk) begin
    if (rst) begin
      int_stat_q <= `SCSTS_RST_EVENTS;
    end else if (wr_stat) begin
      int_stat_q <= (int_stat_q & ~hwdata[`SCSTS_EV_W-1:0]) | events;
    end else begin
      int_stat_q <= int_stat_q | events;
    end
  end

  // Mask resets to all zero so nothing interrupts before software opts in
  always_ff @(posedge clk) begin
    if (rst) begin
      int_mask_q <= `SCSTS_RST_EVENTS;
    end else if (wr_mask) begin
      int_mask_q <= hwdata[`SCSTS_EV_W-1:0];
    end
  end

  // Registered so irq comes straight from a flip-flop, one cycle behind the status
  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat_q & int_mask_q);
    end
  end

  // Read data is sampled at the address phase; reads touch no state
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (acc_idx)
      `SCSTS_IDX_STAT0: rd_mux[7:0] = stat0;
      `SCSTS_IDX_STAT1: rd_mux[7:0] = stat1;
      `SCSTS_IDX_STAT2: rd_mux[7:0] = stat2;
      `SCSTS_IDX_INT_STAT: rd_mux[`SCSTS_EV_W-1:0] = int_stat_q;
      `SCSTS_IDX_INT_MASK: rd_mux[`SCSTS_EV_W-1:0] = int_mask_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (acc && !hwrite && word_ok) begin
      hrdata <= rd_mux;
    end else begin
      hrdata <= 32'h0000_0000;
    end
  end

  // Zero wait states, always OKAY; status writes fall through unstored
  always_ff @(posedge clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

endmodule : scsts_core

// ---- core/scsts_consts.svh ----
// Offsets, field positions, reset values and widths for the SCSI status registers
`ifndef SCSTS_CONSTS_SVH
`define SCSTS_CONSTS_SVH

`define SCSTS_IDX_W 6
`define SCSTS_IDX_STAT0 6'h0d
`define SCSTS_IDX_STAT1 6'h0e
`define SCSTS_IDX_STAT2 6'h0f
`define SCSTS_IDX_INT_STAT 6'h10
`define SCSTS_IDX_INT_MASK 6'h11

`define SCSTS_HSIZE_WORD 3'h2

`define SCSTS_S0_IN_LOW 7
`define SCSTS_S0_OUTBUF_LOW 6
`define SCSTS_S0_OUTLAT_LOW 5
`define SCSTS_S0_AIP 4
`define SCSTS_S0_LOST 3
`define SCSTS_S0_WON 2
`define SCSTS_S0_RST 1
`define SCSTS_S0_PAR_LOW 0

`define SCSTS_S1_CNT_HI 7
`define SCSTS_S1_CNT_LO 4
`define SCSTS_S1_LPAR_LOW 3
`define SCSTS_S1_MSG 2
`define SCSTS_S1_CD 1
`define SCSTS_S1_IO 0

`define SCSTS_S2_IN_HIGH 7
`define SCSTS_S2_OUTBUF_HIGH 6
`define SCSTS_S2_OUTLAT_HIGH 5
`define SCSTS_S2_CNT_MSB 4
`define SCSTS_S2_LPAR_HIGH 3
`define SCSTS_S2_LAST_DISCONNECT 1
`define SCSTS_S2_PAR_HIGH 0

`define SCSTS_FIFO_CNT_W 5
`define SCSTS_FIFO_CNT_MSB 4

`define SCSTS_EV_W 4
`define SCSTS_EV_LOST 0
`define SCSTS_EV_WON 1
`define SCSTS_EV_RST 2
`define SCSTS_EV_PHASE 3

`define SCSTS_PIN_W 7
`define SCSTS_PIN_RST 0
`define SCSTS_PIN_SDP0 1
`define SCSTS_PIN_SDP1 2
`define SCSTS_PIN_REQ 3
`define SCSTS_PIN_MSG 4
`define SCSTS_PIN_CD 5
`define SCSTS_PIN_IO 6

`define SCSTS_RST_BYTE 8'h00
`define SCSTS_RST_PINS 7'h7f
`define SCSTS_RST_LAST_DISCONNECT 1'b1
`define SCSTS_RST_EVENTS 4'h0

`endif

// ---- core/scsts_pkg.sv ----
// Types shared by the SCSI status register block
package scsts_pkg;

  typedef enum logic [1:0] {
    SCSTS_IDLE = 2'b00,
    SCSTS_BUSY = 2'b01,
    SCSTS_NONSEQ = 2'b10,
    SCSTS_SEQ = 2'b11
  } scsts_htrans_t;

  typedef logic [7:0] scsts_byte_t;

endpackage : scsts_pkg

// ---- testbench/scsts_core_assertions.sv ----
// Port-level checker for the SCSI status register block
`timescale 1ns/100ps
module scsts_core_assertions #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire scsts_pkg::scsts_htrans_t htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic irq,
  input wire logic in_latch_low_full,
  input wire logic in_latch_high_full,
  input wire logic out_buffer_low_full,
  input wire logic out_buffer_high_full,
  input wire logic out_latch_low_full,
  input wire logic out_latch_high_full,
  input wire logic [4:0] sync_fifo_count,
  input wire logic connected_flag
);
  import scsts_pkg::*;
  logic rd;
  assign rd = hsel && hready && htrans == SCSTS_NONSEQ && !hwrite && hsize == 3'h2;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or error");
  s0_full_a: assert property (rd && haddr == 8'h34 |=>
    hrdata[7:5] == {$past(in_latch_low_full), $past(out_buffer_low_full), $past(out_latch_low_full)})
    else $error("status zero fill flags wrong");
  s2_full_a: assert property (rd && haddr == 8'h3c |=>
    {hrdata[7:4], hrdata[2]} == {$past(in_latch_high_full), $past(out_buffer_high_full),
    $past(out_latch_high_full), $past(sync_fifo_count[4]), 1'b0}) else $error("status two flags wrong");
  fifo_low_a: assert property (rd && haddr == 8'h38 |=>
    hrdata[7:4] == $past(sync_fifo_count[3:0])) else $error("fifo count wrong");
  arb_excl_a: assert property (rd && haddr == 8'h34 |=> $onehot0(hrdata[4:2]))
    else $error("arbitration flags overlap");
  last_disconnect_set_a: assert property (rd && haddr == 8'h3c && !connected_flag && !$past(connected_flag) |=>
    hrdata[1]) else $error("disconnect flag clear");
  read_zero_a: assert property (!rd |=> hrdata == 32'h0) else $error("data outside read");
  upper_zero_a: assert property (rd |=> hrdata[31:8] == 24'h0) else $error("upper data bits set");
  irq_rst_a: assert property ($fell(rst) |-> !irq) else $error("irq after reset");
  cover property (rd && haddr == 8'h34);
  cover property (irq);
  cover property (rd && haddr == 8'h3c && sync_fifo_count == 5'h10);
endmodule : scsts_core_assertions

// ---- testbench/scsts_scsi_dev.sv ----
// Far-side SCSI device model driving control and parity lines
`timescale 1ns/100ps
module scsts_scsi_dev (
  input wire logic clk,
  output logic scsi_rst_n,
  output logic scsi_sdp0_n,
  output logic scsi_sdp1_n,
  output logic scsi_req_n,
  output logic [2:0] ph_n
);
  // Terminators pull released lines to their inactive high level
  initial {scsi_rst_n, scsi_sdp0_n, scsi_sdp1_n, scsi_req_n, ph_n} = 7'h7f;
  task automatic lines(input logic [2:0] act);
    @(posedge clk);
    {scsi_rst_n, scsi_sdp0_n, scsi_sdp1_n} <= ~act;
  endtask : lines
  // Phase settles well before REQ, as the core samples it on the synced REQ edge
  task automatic phase(input logic [2:0] ph);
    @(posedge clk);
    ph_n <= ~ph;
    repeat (4) @(posedge clk);
    scsi_req_n <= 1'b0;
    repeat (4) @(posedge clk);
    scsi_req_n <= 1'b1;
    repeat (2) @(posedge clk);
    ph_n <= 3'h7;
  endtask : phase
endmodule : scsts_scsi_dev

// ---- testbench/scsts_core_tb.sv ----
// Self-checking bench for the SCSI status register block
`timescale 1ns/100ps
module scsts_core_tb;
  import scsts_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  scsts_htrans_t htrans = SCSTS_IDLE;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [5:0] full_q = 6'h00;
  logic [5:0] pl_q = 6'h00;
  logic [4:0] cnt_q = 5'h00;
  logic mode_q = 1'b0;
  logic interrupt_status_q = 1'b0;
  logic conn_q = 1'b0;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, irq, scsi_rst_n, scsi_sdp0_n, scsi_sdp1_n, scsi_req_n;
  wire logic [2:0] ph_n;
  wire logic hready = hreadyout;
  logic [31:0] d;
  logic [5:0] f;
  int n_fail = 0;
  int cmp_count = 0;
  int cv[4] = '{0, 1, 15, 16};
  always #4 clk = ~clk;
  scsts_core dut (
    .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .irq,
    .in_latch_low_full(full_q[5]), .out_buffer_low_full(full_q[4]), .out_latch_low_full(full_q[3]),
    .in_latch_high_full(full_q[2]), .out_buffer_high_full(full_q[1]), .out_latch_high_full(full_q[0]),
    .arb_started(pl_q[0]), .arb_sel_by_other(pl_q[1]), .arb_success(pl_q[2]), .block_move_exec(pl_q[3]),
    .in_latch_low_load(pl_q[4]), .in_latch_high_load(pl_q[5]), .sync_fifo_count(cnt_q),
    .arb_mode_full_sel(mode_q), .interrupt_status_reset(interrupt_status_q), .connected_flag(conn_q),
    .scsi_rst_n, .scsi_sdp0_n, .scsi_sdp1_n, .scsi_req_n,
    .scsi_msg_n(ph_n[2]), .scsi_cd_n(ph_n[1]), .scsi_io_n(ph_n[0])
  );
  scsts_scsi_dev dev (.clk, .scsi_rst_n, .scsi_sdp0_n, .scsi_sdp1_n, .scsi_req_n, .ph_n);
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= SCSTS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= SCSTS_IDLE;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 32'h0, d);
    cmp(d, {24'h0, e});
  endtask : chk
  task automatic pulse(input int i);
    @(posedge clk);
    pl_q <= 6'h01 << i;
    @(posedge clk);
    pl_q <= 6'h00;
  endtask : pulse
  // Irq is registered behind the status update, so allow two edges
  task automatic wirq(input logic [7:0] a, input logic [31:0] v, input logic e);
    xfer(1'b1, a, v, d);
    repeat (2) @(posedge clk);
    cmp({31'h0, irq}, {31'h0, e});
  endtask : wirq
  task stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(8'h34, 8'h00);
    chk(8'h38, 8'h00);
    chk(8'h3c, 8'h02);
    chk(8'h80, 8'h00);
    xfer(1'b1, 8'h34, 32'hff, d);
    chk(8'h34, 8'h00);
    for (int i = 0; i < 6; i++) begin
      f = 6'h20 >> i;
      full_q <= f;
      chk(8'h34, {f[5:3], 5'h00});
      chk(8'h3c, {f[2:0], 5'h02});
    end
    full_q <= 6'h00;
    foreach (cv[i]) begin
      cnt_q <= 5'(cv[i]);
      chk(8'h38, {cv[i][3:0], 4'h0});
      chk(8'h3c, {3'h0, cv[i][4], 4'h2});
    end
    cnt_q <= 5'h00;
    xfer(1'b1, 8'h44, 32'hf, d);
    pulse(0);
    chk(8'h34, 8'h10);
    pulse(2);
    chk(8'h34, 8'h00);
    chk(8'h40, 8'h00);
    mode_q <= 1'b1;
    pulse(0);
    pulse(2);
    chk(8'h34, 8'h04);
    wirq(8'h44, 32'hf, 1'b1);
    wirq(8'h44, 32'h0, 1'b0);
    wirq(8'h40, 32'hf, 1'b0);
    wirq(8'h44, 32'hf, 1'b0);
    pulse(0);
    pulse(1);
    chk(8'h34, 8'h08);
    chk(8'h40, 8'h01);
    wirq(8'h40, 32'hf, 1'b0);
    dev.phase(3'b101);
    chk(8'h38, 8'h05);
    dev.phase(3'b010);
    chk(8'h38, 8'h02);
    conn_q <= 1'b1;
    chk(8'h3c, 8'h02);
    pulse(3);
    chk(8'h3c, 8'h00);
    conn_q <= 1'b0;
    chk(8'h3c, 8'h02);
    dev.lines(3'h7);
    repeat (4) @(posedge clk);
    chk(8'h34, 8'h0b);
    chk(8'h3c, 8'h03);
    chk(8'h40, 8'h0c);
    pulse(4);
    pulse(5);
    dev.lines(3'h0);
    repeat (4) @(posedge clk);
    chk(8'h38, 8'h0a);
    chk(8'h3c, 8'h0a);
    interrupt_status_q <= 1'b1;
    chk(8'h34, 8'h0a);
    stop_test;
  end
  // The sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    stop_test;
  end
endmodule : scsts_core_tb
bind scsts_core scsts_core_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hrdata, .hreadyout, .hresp, .irq,
  .in_latch_low_full, .in_latch_high_full, .out_buffer_low_full, .out_buffer_high_full,
  .out_latch_low_full, .out_latch_high_full, .sync_fifo_count, .connected_flag
);
